/* File: rtl/srg_map.svh */
// Register offsets, field positions and reset values of the rate generator.
`ifndef SRG_MAP_SVH
`define SRG_MAP_SVH
`define SRG_OFS_CTRL 8'h00
`define SRG_OFS_CFG_A 8'h04
`define SRG_OFS_CFG_B 8'h08
`define SRG_OFS_PIN 8'h0C
`define SRG_OFS_STAT 8'h10
`define SRG_CTRL_GEN 0
`define SRG_CTRL_FRAME 1
`define SRG_CTRL_RX 2
`define SRG_CTRL_TX 3
`define SRG_A_DIV 7:0
`define SRG_A_WID 15:8
`define SRG_B_PER 11:0
`define SRG_B_SEL_LO 12
`define SRG_B_FROM_GEN 13
`define SRG_B_SYNC 15
`define SRG_PIN_SEL_HI 0
`define SRG_PIN_RX_CLK 1
`define SRG_PIN_TX_CLK 2
`define SRG_PIN_TX_SYNC 3
`define SRG_STAT_FLD 4:0
`define SRG_RST_WORD 32'h0000_0000
`define SRG_ONE8 8'h01
`define SRG_ONE12 12'h001
`endif

/* File: rtl/srg_pkg.sv */
// Types shared by the rate generator modules.
package srg_pkg;
  typedef enum logic [2:0] {
    SRG_M_DIV2 = 3'h1,
    SRG_M_LOW = 3'h2,
    SRG_M_RUN = 3'h4
  } srg_mode_t;
  typedef enum logic [1:0] {
    SRG_SRC_RSVD = 2'h0,
    SRG_SRC_CPU = 2'h1,
    SRG_SRC_RXPIN = 2'h2,
    SRG_SRC_TXPIN = 2'h3
  } srg_src_t;
  typedef struct packed {
    logic clk;
    logic run;
    logic rise;
    logic [7:0] cnt;
  } srg_div_st_t;
  typedef struct packed {
    srg_mode_t mode;
    logic hold;
    logic gen_en, frame_en, rx_en, tx_en;
    logic [7:0] div;
    logic [7:0] wid;
    logic [11:0] per;
    logic sel_lo, sel_hi, from_gen, sync_en, rx_ci, tx_ci, tx_si;
    logic rxc_a, rxc_b, rxc_p;
    logic txc_a, txc_b, txc_p;
    logic fsr_a, fsr_b, fsr_prev;
    logic pend;
    logic fs;
    logic [11:0] pcnt;
    logic [7:0] wcnt;
    logic [31:0] prdata;
  } srg_top_st_t;
endpackage

/* File: rtl/srg_div_if.sv */
// Link between the frame logic and the bit-clock divider.
`timescale 1ns/1ns
interface srg_div_if;
  logic tick;
  logic resync;
  srg_pkg::srg_mode_t mode;
  logic [7:0] div;
  logic bclk;
  logic rise;
  modport ctl (output tick, output resync, output mode, output div, input bclk, input rise);
  modport gen (input tick, input resync, input mode, input div, output bclk, output rise);
endinterface

/* File: rtl/srg_clk_div.sv */
// Bit-clock divider with restart, hold-low and divide-by-two reset modes.
`timescale 1ns/1ns
`include "srg_map.svh"
module srg_clk_div (
  input logic core_clk,
  input logic rst_n,
  srg_div_if.gen dif
);
  srg_pkg::srg_div_st_t st_r, st_nxt;
  logic [7:0] hi_m1;
  logic [7:0] lo_m1;
  logic [8:0] h_hi_r;

  assign hi_m1 = dif.div >> 1;
  assign lo_m1 = 8'(((({1'b0, dif.div} + 9'h001) >> 1)) - 9'h001);
  assign dif.bclk = st_r.clk;
  assign dif.rise = st_r.rise;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rise = 1'b0;
    case (dif.mode)
      srg_pkg::SRG_M_DIV2: begin
        st_nxt.clk = ~st_r.clk;
        st_nxt.run = 1'b0;
      end
      srg_pkg::SRG_M_LOW: begin
        st_nxt.clk = 1'b0;
        st_nxt.run = 1'b0;
      end
      srg_pkg::SRG_M_RUN: begin
        if (dif.tick) begin
          if (!st_r.run || dif.resync) begin
            st_nxt.clk = 1'b1;
            st_nxt.cnt = hi_m1;
            st_nxt.run = 1'b1;
            st_nxt.rise = 1'b1;
          end else if (st_r.cnt != 8'h00) begin
            st_nxt.cnt = st_r.cnt - `SRG_ONE8;
          end else if (st_r.clk && dif.div != 8'h00) begin
            st_nxt.clk = 1'b0;
            st_nxt.cnt = lo_m1;
          end else begin
            st_nxt.clk = 1'b1;
            st_nxt.cnt = hi_m1;
            st_nxt.rise = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.clk = 1'b0;
        st_nxt.run = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      h_hi_r <= 9'h000;
    end else begin
      st_r <= st_nxt;
      if (st_nxt.rise) begin
        h_hi_r <= 9'h000;
      end else if (dif.tick && st_r.clk) begin
        h_hi_r <= h_hi_r + 9'h001;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_high_len;
    @(posedge core_clk) disable iff (!rst_n)
    $fell(st_r.clk) && dif.mode == srg_pkg::SRG_M_RUN && $past(dif.mode == srg_pkg::SRG_M_RUN)
      |-> h_hi_r == {1'b0, hi_m1} + 9'h001;
  endproperty
  a_high_len: assert property (p_high_len) else $error("bit clock high phase has wrong length");
  property p_start_high;
    @(posedge core_clk) disable iff (!rst_n)
    dif.mode == srg_pkg::SRG_M_RUN && !st_r.run && dif.tick |=> st_r.clk && st_r.rise;
  endproperty
  a_start_high: assert property (p_start_high) else $error("bit clock did not start high");
endmodule

/* File: rtl/srg_rate_gen.sv */
// Sample rate generator: APB registers, input clock select, external sync and frame-sync generation.
// Contract
// - Gated external clock: pin sync edge pulses frame
// - Free frame starts spaced period plus one
// - Sync edge restarts bit clock, pulses frame
// - Bit clock restarts high after resync
// - Sync pin sampled on input clock edge
// - Sync enabled with a pin clock: period field ignored
// - Sync off: free clock, period field rules
// - Resync only with a pin clock selected
// - Device reset clears all reset-control bits
// - Device reset: CPU clock halved, sync low
// - Software reset: clock and sync low
// - First input edge drives bit clock high
// - First frame after period plus one
// - Two bits select the input clock
// - Bit clock is input over divide plus one
// - Frame pulse lasts width plus one
// - Frames only with both enables set
// - Even divide gives longer high phase
`timescale 1ns/1ns
`include "srg_map.svh"
module srg_rate_gen (
  input logic core_clk,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic rx_ext_clock_pin,
  input logic tx_ext_clock_pin,
  input logic rx_frame_sync_pin,
  output logic gen_bit_clock,
  output logic gen_frame_sync,
  output logic rx_reset_n,
  output logic tx_reset_n,
  output logic rx_clock_internal,
  output logic tx_clock_internal,
  output logic tx_sync_internal,
  output logic tx_sync_from_gen
);
  srg_pkg::srg_top_st_t st_r, st_nxt;
  srg_pkg::srg_src_t src;
  logic tick;
  logic sync_act;
  logic sync_edge;
  logic start;
  logic wr;
  logic hit;
  logic [31:0] rd_word;

  srg_div_if dif ();

  srg_clk_div srg_clk_div_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .dif(dif)
  );

  // ****************************************
  // Input clock selection
  // ****************************************
  // Pin clocks become a one-cycle enable on their synchronised rising edge, so they must run
  // below half the core clock to be seen at all.
  assign src = srg_pkg::srg_src_t'({st_r.sel_hi, st_r.sel_lo});
  always_comb begin
    case (src)
      srg_pkg::SRG_SRC_CPU: tick = 1'b1;
      srg_pkg::SRG_SRC_RXPIN: tick = st_r.rxc_b & ~st_r.rxc_p;
      srg_pkg::SRG_SRC_TXPIN: tick = st_r.txc_b & ~st_r.txc_p;
      default: tick = 1'b0;
    endcase
  end

  assign sync_act = st_r.sync_en && (src == srg_pkg::SRG_SRC_RXPIN || src == srg_pkg::SRG_SRC_TXPIN);
  assign sync_edge = sync_act && tick && st_r.fsr_b && !st_r.fsr_prev;
  assign start = sync_act ? st_r.pend : (st_r.pcnt == st_r.per);

  assign dif.tick = tick;
  assign dif.resync = sync_edge;
  assign dif.mode = st_r.mode;
  assign dif.div = st_r.div;

  // ****************************************
  // Register bus
  // ****************************************
  assign wr = psel && penable && pwrite;
  // No wait states: every access ends in its first access cycle, and read data, captured in the
  // setup cycle, stands through that access cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = st_r.prdata;

  always_comb begin
    hit = 1'b1;
    rd_word = `SRG_RST_WORD;
    if (paddr == `SRG_OFS_CTRL) begin
      rd_word[`SRG_CTRL_GEN] = st_r.gen_en;
      rd_word[`SRG_CTRL_FRAME] = st_r.frame_en;
      rd_word[`SRG_CTRL_RX] = st_r.rx_en;
      rd_word[`SRG_CTRL_TX] = st_r.tx_en;
    end else if (paddr == `SRG_OFS_CFG_A) begin
      rd_word[`SRG_A_DIV] = st_r.div;
      rd_word[`SRG_A_WID] = st_r.wid;
    end else if (paddr == `SRG_OFS_CFG_B) begin
      rd_word[`SRG_B_PER] = st_r.per;
      rd_word[`SRG_B_SEL_LO] = st_r.sel_lo;
      rd_word[`SRG_B_FROM_GEN] = st_r.from_gen;
      rd_word[`SRG_B_SYNC] = st_r.sync_en;
    end else if (paddr == `SRG_OFS_PIN) begin
      rd_word[`SRG_PIN_SEL_HI] = st_r.sel_hi;
      rd_word[`SRG_PIN_RX_CLK] = st_r.rx_ci;
      rd_word[`SRG_PIN_TX_CLK] = st_r.tx_ci;
      rd_word[`SRG_PIN_TX_SYNC] = st_r.tx_si;
    end else if (paddr == `SRG_OFS_STAT) begin
      rd_word[`SRG_STAT_FLD] = {src != srg_pkg::SRG_SRC_RSVD, st_r.hold, sync_act, st_r.fs, dif.bclk};
    end else begin
      hit = 1'b0;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    // Each pin passes two flops before use; the third stage only keeps the old level for the edge test.
    st_nxt.rxc_a = rx_ext_clock_pin;
    st_nxt.rxc_b = st_r.rxc_a;
    st_nxt.rxc_p = st_r.rxc_b;
    st_nxt.txc_a = tx_ext_clock_pin;
    st_nxt.txc_b = st_r.txc_a;
    st_nxt.txc_p = st_r.txc_b;
    st_nxt.fsr_a = rx_frame_sync_pin;
    st_nxt.fsr_b = st_r.fsr_a;
    if (tick) begin
      st_nxt.fsr_prev = st_r.fsr_b;
    end
    if (psel && !penable && !pwrite) begin
      st_nxt.prdata = rd_word;
    end
    if (wr && paddr == `SRG_OFS_CTRL) begin
      st_nxt.gen_en = pwdata[`SRG_CTRL_GEN];
      st_nxt.frame_en = pwdata[`SRG_CTRL_FRAME];
      st_nxt.rx_en = pwdata[`SRG_CTRL_RX];
      st_nxt.tx_en = pwdata[`SRG_CTRL_TX];
    end else if (wr && paddr == `SRG_OFS_CFG_A) begin
      st_nxt.div = pwdata[`SRG_A_DIV];
      st_nxt.wid = pwdata[`SRG_A_WID];
    end else if (wr && paddr == `SRG_OFS_CFG_B) begin
      st_nxt.per = pwdata[`SRG_B_PER];
      st_nxt.sel_lo = pwdata[`SRG_B_SEL_LO];
      st_nxt.from_gen = pwdata[`SRG_B_FROM_GEN];
      st_nxt.sync_en = pwdata[`SRG_B_SYNC];
    end else if (wr && paddr == `SRG_OFS_PIN) begin
      st_nxt.sel_hi = pwdata[`SRG_PIN_SEL_HI];
      st_nxt.rx_ci = pwdata[`SRG_PIN_RX_CLK];
      st_nxt.tx_ci = pwdata[`SRG_PIN_TX_CLK];
      st_nxt.tx_si = pwdata[`SRG_PIN_TX_SYNC];
    end
    // The halved CPU clock of a device reset lasts until software first enables the generator.
    if (st_r.gen_en) begin
      st_nxt.hold = 1'b0;
    end
    // Leaving either reset state restarts the divider on its next input tick.
    case (st_r.mode)
      srg_pkg::SRG_M_DIV2: begin
        if (st_r.gen_en) begin
          st_nxt.mode = srg_pkg::SRG_M_RUN;
        end
      end
      srg_pkg::SRG_M_LOW: begin
        if (st_r.gen_en) begin
          st_nxt.mode = srg_pkg::SRG_M_RUN;
        end
      end
      srg_pkg::SRG_M_RUN: begin
        if (!st_r.gen_en) begin
          st_nxt.mode = srg_pkg::SRG_M_LOW;
        end
      end
      default: st_nxt.mode = srg_pkg::SRG_M_LOW;
    endcase
    // Frame sync: counters sit at zero while disabled, so the first frame after enabling
    // waits a full period rather than firing at once.
    if (st_r.mode != srg_pkg::SRG_M_RUN || !st_r.frame_en) begin
      st_nxt.fs = 1'b0;
      st_nxt.pcnt = 12'h000;
      st_nxt.wcnt = 8'h00;
      st_nxt.pend = 1'b0;
    end else begin
      if (dif.rise) begin
        if (st_r.fs) begin
          if (st_r.wcnt == st_r.wid) begin
            st_nxt.fs = 1'b0;
          end else begin
            st_nxt.wcnt = st_r.wcnt + `SRG_ONE8;
          end
        end
        if (!sync_act) begin
          st_nxt.pcnt = start ? 12'h000 : st_r.pcnt + `SRG_ONE12;
        end
        if (start) begin
          st_nxt.fs = 1'b1;
          st_nxt.wcnt = 8'h00;
        end
      end
      // A new edge wins over the clear, so a pulse arriving with the pending start is not lost.
      if (sync_edge) begin
        st_nxt.pend = 1'b1;
      end else if (dif.rise && start) begin
        st_nxt.pend = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.hold <= 1'b1;
      st_r.mode <= srg_pkg::SRG_M_DIV2;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gen_bit_clock = dif.bclk;
  assign gen_frame_sync = st_r.fs;
  assign rx_reset_n = st_r.rx_en;
  assign tx_reset_n = st_r.tx_en;
  assign rx_clock_internal = st_r.rx_ci;
  assign tx_clock_internal = st_r.tx_ci;
  assign tx_sync_internal = st_r.tx_si;
  assign tx_sync_from_gen = st_r.from_gen;

  // ****************************************
  // Checks
  // ****************************************
  // Helper counters measure frame period and width in bit-clock rises; a register write or
  // a reset state in between voids the period measurement.
  logic [12:0] h_per_r;
  logic h_per_ok_r;
  logic [8:0] h_wid_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      h_per_r <= 13'h0000;
      h_per_ok_r <= 1'b0;
      h_wid_r <= 9'h000;
    end else begin
      if (gen_frame_sync && !$past(gen_frame_sync)) begin
        h_per_r <= {12'h000, dif.rise};
        h_per_ok_r <= !wr && !sync_act;
      end else if (dif.rise) begin
        h_per_r <= h_per_r + 13'h0001;
      end
      if (wr || st_r.mode != srg_pkg::SRG_M_RUN) begin
        h_per_ok_r <= 1'b0;
      end
      if (!gen_frame_sync) begin
        h_wid_r <= 9'h000;
      end else if (dif.rise) begin
        h_wid_r <= h_wid_r + 9'h001;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_sw_low;
    st_r.mode == srg_pkg::SRG_M_LOW && $past(st_r.mode == srg_pkg::SRG_M_LOW) |-> !gen_bit_clock && !gen_frame_sync;
  endproperty
  a_sw_low: assert property (p_sw_low) else $error("outputs not low in software reset");
  // The first edge after reset release still shows the reset level, so it is left out.
  property p_div2;
    st_r.mode == srg_pkg::SRG_M_DIV2 && $past(st_r.mode == srg_pkg::SRG_M_DIV2) && $past(rst_n)
      |-> gen_bit_clock != $past(gen_bit_clock) && !gen_frame_sync;
  endproperty
  a_div2: assert property (p_div2) else $error("device reset clock is not halved");
  property p_hold_ctrl;
    st_r.hold |-> !st_r.rx_en && !st_r.tx_en && st_r.mode == srg_pkg::SRG_M_DIV2 || st_r.gen_en;
  endproperty
  a_hold_ctrl: assert property (p_hold_ctrl) else $error("control bits set during device reset");
  property p_fs_enable;
    $rose(gen_frame_sync) |-> $past(st_r.frame_en) && $past(st_r.mode == srg_pkg::SRG_M_RUN);
  endproperty
  a_fs_enable: assert property (p_fs_enable) else $error("frame sync without enables");
  property p_fs_width;
    $fell(gen_frame_sync) && st_r.mode == srg_pkg::SRG_M_RUN && st_r.frame_en && !wr
      |-> h_wid_r == {1'b0, st_r.wid} + 9'h001;
  endproperty
  a_fs_width: assert property (p_fs_width) else $error("frame sync width wrong");
  property p_period;
    $rose(gen_frame_sync) && h_per_ok_r && !sync_act |-> h_per_r == {1'b0, st_r.per} + 13'h0001;
  endproperty
  a_period: assert property (p_period) else $error("free frame period wrong");
  property p_resync_high;
    sync_edge && st_r.mode == srg_pkg::SRG_M_RUN |=> gen_bit_clock && dif.rise;
  endproperty
  a_resync_high: assert property (p_resync_high) else $error("bit clock not restarted high");
  property p_resync_src;
    sync_edge |-> src == srg_pkg::SRG_SRC_RXPIN || src == srg_pkg::SRG_SRC_TXPIN;
  endproperty
  a_resync_src: assert property (p_resync_src) else $error("resync with CPU clock selected");
  property p_sync_fs;
    sync_edge && st_r.frame_en && st_r.mode == srg_pkg::SRG_M_RUN && !wr |-> ##2 gen_frame_sync;
  endproperty
  a_sync_fs: assert property (p_sync_fs) else $error("no frame sync after sync edge");
  property p_sample;
    !tick |=> $stable(st_r.fsr_prev);
  endproperty
  a_sample: assert property (p_sample) else $error("sync pin sampled off the input edge");
  property p_sync_only;
    $rose(gen_frame_sync) && sync_act && $past(sync_act) |-> $past(st_r.pend);
  endproperty
  a_sync_only: assert property (p_sync_only) else $error("frame sync without external edge");
  property p_sw_enter;
    st_r.mode == srg_pkg::SRG_M_RUN && !st_r.gen_en |=> st_r.mode == srg_pkg::SRG_M_LOW;
  endproperty
  a_sw_enter: assert property (p_sw_enter) else $error("software reset not entered");
  property p_rsvd_idle;
    src == srg_pkg::SRG_SRC_RSVD && st_r.mode == srg_pkg::SRG_M_RUN |=> $stable(gen_bit_clock);
  endproperty
  a_rsvd_idle: assert property (p_rsvd_idle) else $error("bit clock moved with no input selected");

  c_sync: cover property (sync_edge ##2 gen_frame_sync);
  c_free: cover property (!sync_act && $rose(gen_frame_sync) && h_per_ok_r);
  c_leave_div2: cover property (st_r.mode == srg_pkg::SRG_M_DIV2 ##1 st_r.mode == srg_pkg::SRG_M_RUN);
  c_resync: cover property (sync_edge && gen_bit_clock);
  c_sw_reset: cover property (st_r.mode == srg_pkg::SRG_M_RUN ##1 st_r.mode == srg_pkg::SRG_M_LOW);
endmodule

/* File: test/srg_ext_dev.sv */
// External device model: pin clocks and receive frame-sync pulses.
`timescale 1ns/1ns
module srg_ext_dev #(
  parameter int HALF_NS = 200
) (
  input wire logic fs_go,
  input wire logic [7:0] fs_len,
  output logic rx_clk,
  output logic tx_clk,
  output logic fs_pin
);
  // The pin clock is offset so that its edges never land on a core clock edge.
  initial begin
    rx_clk = 1'b0;
    #7;
    forever #(HALF_NS) rx_clk = ~rx_clk;
  end
  assign tx_clk = rx_clk;
  // The pulse moves on a falling pin edge, so the rising edge samples it cleanly.
  initial begin
    fs_pin = 1'b0;
    forever begin
      @(posedge fs_go);
      @(negedge rx_clk);
      fs_pin = 1'b1;
      repeat (fs_len) @(negedge rx_clk);
      fs_pin = 1'b0;
    end
  end
endmodule

/* File: test/srg_rate_gen_tb_top.sv */
// Self-checking bench for the rate generator: registers, free running and external sync.
`timescale 1ns/1ns
`include "srg_map.svh"
module srg_rate_gen_tb_top;
  logic core_clk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fs_go = 1'b0;
  logic [7:0] paddr = 8'h00, fs_len = 8'h01;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, perr, rx_pin, tx_pin, fs_pin, bclk, fsync, rx_run, tx_run, rx_ci, tx_ci, tx_si, tx_fg;
  logic [1:0] s;
  logic fresh = 1'b1;
  int fail_count = 0, n_compared = 0, cyc = 0, n, h, l, e, tp, dv, pr, wd;

  srg_rate_gen srg_rate_gen_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_ext_clock_pin(rx_pin), .tx_ext_clock_pin(tx_pin), .rx_frame_sync_pin(fs_pin), .gen_bit_clock(bclk),
    .gen_frame_sync(fsync), .rx_reset_n(rx_run), .tx_reset_n(tx_run), .rx_clock_internal(rx_ci),
    .tx_clock_internal(tx_ci), .tx_sync_internal(tx_si), .tx_sync_from_gen(tx_fg));
  srg_ext_dev srg_ext_dev_inst (.fs_go(fs_go), .fs_len(fs_len), .rx_clk(rx_pin), .tx_clk(tx_pin),
    .fs_pin(fs_pin));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // *****
  // Tasks
  // *****
  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Entered just after a rising edge; leaves one idle edge so the next call never re-drives psel at once.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      tally_and_finish();
    end
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  function automatic logic pick(input logic k);
    return k ? fsync : bclk;
  endfunction

  task automatic until_lvl(input logic k, input logic v, output int m);
    m = 0;
    while (pick(k) !== v && m < 3000) begin
      @(posedge core_clk);
      m++;
    end
  endtask

  task automatic rises(input logic k, input int t, output int m);
    logic p;
    m = 0;
    repeat (t) begin
      p = pick(k);
      @(posedge core_clk);
      if (p === 1'b0 && pick(k) === 1'b1) m++;
    end
  endtask

  task automatic highs(input logic [1:0] msk, input int t, output int m);
    m = 0;
    repeat (t) begin
      @(posedge core_clk);
      if (({fsync, bclk} & msk) !== 2'b00) m++;
    end
  endtask

  task automatic dev_reset();
    logic b;
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("outs_in_reset", 32'h0, {30'h0, bclk, fsync});
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 6; i++) begin
      b = bclk;
      @(posedge core_clk);
      chk("bclk_half", {31'h0, ~b}, {31'h0, bclk});
      chk("fs_idle", 32'h0, {31'h0, fsync});
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reg_reset", 32'h0, q);
    end
    chk("sect_reset", 32'h0, {30'h0, rx_run, tx_run});
    fresh = 1'b1;
  endtask

  // Sections are held in reset while the generator is reprogrammed, then released in order.
  task automatic cfg(input logic [1:0] src, input logic sy, input logic fr, output int m);
    apb(1'b1, `SRG_OFS_CTRL, 32'h0);
    // The outputs settle two cycles after the write; straight after a device reset the clock stays halved.
    repeat (2) @(posedge core_clk);
    highs(fresh ? 2'b01 : 2'b11, 40, m);
    chk("sw_reset_low", fresh ? 32'h14 : 32'h0, m);
    fresh = 1'b0;
    apb(1'b1, `SRG_OFS_CFG_A, {16'h0, wd[7:0], dv[7:0]});
    apb(1'b1, `SRG_OFS_CFG_B, {16'h0, sy, 2'b01, src[0], pr[11:0]});
    apb(1'b1, `SRG_OFS_PIN, {28'h0, 3'h7, src[1]});
    repeat (25) @(posedge core_clk);
    apb(1'b1, `SRG_OFS_CTRL, 32'h1);
    if (src != 2'b00) begin
      until_lvl(1'b0, 1'b1, m);
      chk("first_tick_high", 32'h1, {31'h0, m <= tp + 4});
    end
    repeat (2 * (dv + 1) * tp) @(posedge core_clk);
    apb(1'b1, `SRG_OFS_CTRL, 32'hD);
    chk("route_bits", 32'h3F, {26'h0, rx_ci, tx_ci, tx_si, tx_fg, rx_run, tx_run});
    m = 0;
    if (fr) begin
      apb(1'b1, `SRG_OFS_CTRL, 32'hF);
      until_lvl(1'b1, 1'b1, m);
    end
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    void'($urandom(32'h0233C4B1));
    dev_reset();
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {q[30:0], perr});
    apb(1'b0, `SRG_OFS_STAT, 32'h0);
    chk("stat_hold", 32'h4, {28'h0, q[4:1]});
    // Pass 9 uses the CPU clock with sync on, and fires a pin pulse that must be ignored.
    for (int i = 0; i < 12; i++) begin
      s = 2'(i % 3 + 1);
      tp = (i % 3 == 0) ? 1 : 10;
      dv = (i < 3) ? i : (i == 9) ? 5 : $urandom_range(1, 5);
      pr = (i == 9) ? 9 : $urandom_range(2, 9);
      wd = $urandom_range(0, pr - 1);
      cfg(s, i == 9, 1'b1, n);
      e = (pr + 1) * (dv + 1) * tp;
      chk("first_fs", 32'h1, {31'h0, n >= e - (dv + 1) * tp - 2 && n <= e + 6});
      if (dv > 0) begin
        until_lvl(1'b0, 1'b0, n);
        until_lvl(1'b0, 1'b1, n);
        until_lvl(1'b0, 1'b0, h);
        until_lvl(1'b0, 1'b1, l);
        chk("bclk_high", (dv / 2 + 1) * tp, h);
        chk("bclk_low", ((dv + 1) / 2) * tp, l);
      end
      until_lvl(1'b1, 1'b0, n);
      until_lvl(1'b1, 1'b1, n);
      if (i == 9) fs_go <= 1'b1;
      until_lvl(1'b1, 1'b0, h);
      until_lvl(1'b1, 1'b1, l);
      chk("fs_width", (wd + 1) * (dv + 1) * tp, h);
      chk("fs_period", e, h + l);
      fs_go <= 1'b0;
    end
    tp = 10;
    cfg(2'b00, 1'b0, 1'b0, n);
    highs(2'b01, 200, n);
    chk("reserved_src", 32'h0, n);
    tp = 1;
    cfg(2'b01, 1'b0, 1'b0, n);
    highs(2'b10, 300, n);
    chk("no_frame_gate", 32'h0, n);
    dv = 3;
    pr = 2;
    wd = 0;
    tp = 10;
    for (int i = 2; i < 4; i++) begin
      cfg(2'(i), 1'b1, 1'b1, n);
      chk("no_free_fs", 32'h1, {31'h0, n >= 3000});
      apb(1'b0, `SRG_OFS_STAT, 32'h0);
      chk("stat_sync", 32'h5, {29'h0, q[4:2]});
      for (int j = 0; j < 2; j++) begin
        fs_len <= 8'($urandom_range(1, 6));
        fs_go <= 1'b1;
        until_lvl(1'b1, 1'b1, n);
        chk("sync_resp", 32'h1, {31'h0, n <= 35});
        chk("bclk_restart", 32'h1, {31'h0, bclk});
        fs_go <= 1'b0;
        rises(1'b1, 400, n);
        chk("one_fs", 32'h0, n);
      end
    end
    dev_reset();
    tally_and_finish();
  end
endmodule
